// File: core/ebaru_core.sv
// external bus front end: address outputs, muxed address/data, strobe, ready, reset capture
// assumes pins are resolved outside from out/oe_n/pd_en triples, one sys_clk domain
// Functional notes
// - nonmux address appears half a bus clock before muxed address.
// - bus hold or reset floats nonmux address with pulldowns.
// - dram region: row then column driven on nonmux address.
// - upper and lower ranges select dram mode independently.
// - address in first state, data driven or sampled in later states.
// - reset strap can suppress the muxed address phase.
// - muxed lines float in hold, float with pulldowns in reset.
// - muxed pin levels during reset are kept for software reads.
// - strobe pulses with address valid at its falling edge.
// - strobe floats with pulldown during hold or reset.
// - async ready is active high, from the addressed device.
// - unsynchronised ready release may add one wait period.
// - async or sync ready decides whether the transfer ends or waits.
`include "ebaru_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module ebaru_core
   import ebaru_pkg::*;
#(
   parameter int ADDR_W   = `EBARU_ADDR_W,
   parameter int DATA_W   = `EBARU_DATA_W,
   parameter int ROW_BITS = `EBARU_DRAM_ROW_BITS
) (
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire logic              req_valid,
   output logic                   req_ready,
   input  wire logic              req_write,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [DATA_W-1:0] req_wdata,
   input  wire logic              req_upper_region,
   input  wire logic              req_lower_region,
   input  wire logic              dram_upper_en,
   input  wire logic              dram_lower_en,
   output logic [DATA_W-1:0]      rd_data,
   output logic                   done,
   input  wire logic              hold_req,
   output logic                   hold_ack,
   output logic [ADDR_W-1:0]      nonmux_address_out,
   output logic                   nonmux_address_oe_n,
   output logic                   nonmux_address_pd_en,
   input  wire logic [DATA_W-1:0] muxed_addr_data_in,
   output logic [DATA_W-1:0]      muxed_addr_data_out,
   output logic                   muxed_addr_data_oe_n,
   output logic                   muxed_addr_data_pd_en,
   output logic                   ale_out,
   output logic                   ale_oe_n,
   output logic                   ale_pd_en,
   output logic                   bus_clock_out,
   input  wire logic              async_ready_in,
   input  wire logic              sync_ready_in,
   input  wire logic              address_phase_enable_strap,
   output logic [DATA_W-1:0]      reset_config_capture,
   output logic                   address_phase_enabled
);

   ebaru_state_t      state_reg;
   logic              phase_reg;
   logic              hold_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [DATA_W-1:0] wdata_reg;
   logic              write_reg;
   logic              dram_reg;
   logic [ADDR_W-1:0] nonmux_reg;
   logic [DATA_W-1:0] ad_out_reg;
   logic              ad_oe_n_reg;
   logic              ale_reg;
   logic [DATA_W-1:0] rd_data_reg;
   logic              done_reg;
   logic [DATA_W-1:0] capture_reg;
   logic              addr_phase_en_reg;
   logic [DATA_W-1:0] ad_s1_reg;
   logic [DATA_W-1:0] ad_s2_reg;
   logic [1:0]        async_ready_sync_reg;
   logic [1:0]        sync_ready_sync_reg;
   logic [1:0]        hold_sync_reg;
   logic [1:0]        strap_sync_reg;
   logic              tick;
   logic              ready_s;
   logic              take;
   logic              dram_sel;

   // pin synchronisers, kept out of reset so the reset capture sees live levels
   always_ff @(posedge sys_clk) begin
      ad_s1_reg            <= muxed_addr_data_in;
      ad_s2_reg            <= ad_s1_reg;
      async_ready_sync_reg <= {async_ready_sync_reg[0], async_ready_in};
      sync_ready_sync_reg  <= {sync_ready_sync_reg[0], sync_ready_in};
      strap_sync_reg       <= {strap_sync_reg[0], address_phase_enable_strap};
      hold_sync_reg        <= {hold_sync_reg[0], hold_req};
   end

   // combined ready; the sync stages cost the extra wait on a late release
   assign ready_s = async_ready_sync_reg[1] | sync_ready_sync_reg[1];
   // one bus clock spans two sys_clk cycles; tick ends each bus state
   assign tick = phase_reg;
   assign dram_sel = (req_upper_region & dram_upper_en) | (req_lower_region & dram_lower_en);
   assign req_ready = (state_reg == ST_IDLE) & tick & ~hold_sync_reg[1] & ~hold_reg & ~rst;
   assign take = req_ready & req_valid;

   // bus clock divider
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         phase_reg <= 1'b0;
      end else begin
         phase_reg <= ~phase_reg;
      end
   end

   // strap and pin capture happen only while reset is held
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         capture_reg       <= ad_s2_reg;
         addr_phase_en_reg <= strap_sync_reg[1];
      end
   end

   // bus hold is granted only between cycles, and hold wins over a new request
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         hold_reg <= 1'b0;
      end else if (tick && state_reg == ST_IDLE) begin
         hold_reg <= hold_sync_reg[1];
      end
   end

   // bus state sequence
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_reg <= ST_IDLE;
      end else if (take) begin
         state_reg <= ST_T1;
      end else if (tick) begin
         unique case (state_reg)
            ST_IDLE: state_reg <= ST_IDLE;
            ST_T1:   state_reg <= ST_T2;
            ST_T2:   state_reg <= ST_T3;
            ST_T3:   state_reg <= ready_s ? ST_T4 : ST_TW;
            ST_TW:   state_reg <= ready_s ? ST_T4 : ST_TW;
            ST_T4:   state_reg <= ST_IDLE;
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // request latch
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         addr_reg  <= '0;
         wdata_reg <= '0;
         write_reg <= 1'b0;
         dram_reg  <= 1'b0;
      end else if (take) begin
         addr_reg  <= req_addr;
         wdata_reg <= req_wdata;
         write_reg <= req_write;
         dram_reg  <= dram_sel;
      end
   end

   // nonmux address: set at start of the first state, half a bus clock ahead
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         nonmux_reg <= '0;
      end else if (take) begin
         nonmux_reg <= dram_sel ? (req_addr >> ROW_BITS) : req_addr;
      end else if (state_reg == ST_T1 && tick && dram_reg) begin
         nonmux_reg <= {{(ADDR_W-ROW_BITS){1'b0}}, addr_reg[ROW_BITS-1:0]};
      end
   end

   // muxed lines: address in second half of the first state, then data
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ad_out_reg  <= '0;
         ad_oe_n_reg <= 1'b1;
      end else if (state_reg == ST_T1 && !tick) begin
         ad_out_reg  <= addr_reg[DATA_W-1:0];
         ad_oe_n_reg <= ~addr_phase_en_reg;
      end else if (state_reg == ST_T1 && tick) begin
         ad_out_reg  <= wdata_reg;
         ad_oe_n_reg <= ~write_reg;
      end else if (state_reg == ST_T4 && tick) begin
         ad_oe_n_reg <= 1'b1;
      end
   end

   // strobe high over the muxed address half, falls as data begins
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ale_reg <= 1'b0;
      end else begin
         ale_reg <= (state_reg == ST_T1) && !tick;
      end
   end

   // read data taken at the end of the fourth state
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rd_data_reg <= '0;
         done_reg    <= 1'b0;
      end else begin
         done_reg <= (state_reg == ST_T4) && tick;
         if (state_reg == ST_T4 && tick && !write_reg) begin
            rd_data_reg <= ad_s2_reg;
         end
      end
   end

   // pin drive; enables float the pins combinationally so reset acts at once
   assign nonmux_address_out    = nonmux_reg;
   assign nonmux_address_oe_n   = rst | hold_reg;
   assign nonmux_address_pd_en  = rst | hold_reg;
   assign muxed_addr_data_out   = ad_out_reg;
   assign muxed_addr_data_oe_n  = rst | hold_reg | ad_oe_n_reg;
   assign muxed_addr_data_pd_en = rst;
   assign ale_out               = ale_reg;
   assign ale_oe_n              = rst | hold_reg;
   assign ale_pd_en             = rst | hold_reg;
   assign bus_clock_out         = phase_reg;
   assign hold_ack              = hold_reg;
   assign rd_data               = rd_data_reg;
   assign done                  = done_reg;
   assign reset_config_capture  = capture_reg;
   assign address_phase_enabled = addr_phase_en_reg;

   property p_addr_lead;
      @(posedge sys_clk) disable iff (rst)
      $rose(ale_reg) |-> $stable(nonmux_reg) && $past(state_reg) == ST_T1;
   endproperty
   a_addr_lead: assert property (p_addr_lead) else $error("nonmux address not ahead of muxed address");
   property p_hold_nonmux;
      @(posedge sys_clk) disable iff (rst)
      hold_reg |-> nonmux_address_oe_n && nonmux_address_pd_en;
   endproperty
   a_hold_nonmux: assert property (p_hold_nonmux) else $error("nonmux address driven in hold");
   property p_dram_col;
      @(posedge sys_clk) disable iff (rst)
      (state_reg == ST_T1 && tick && dram_reg) |=> nonmux_reg == {{(ADDR_W-ROW_BITS){1'b0}}, addr_reg[ROW_BITS-1:0]};
   endproperty
   a_dram_col: assert property (p_dram_col) else $error("dram column address missing");
   property p_dram_indep;
      @(posedge sys_clk) disable iff (rst)
      (take && req_upper_region && dram_upper_en) |=> dram_reg ##1 (nonmux_reg == (addr_reg >> ROW_BITS));
   endproperty
   a_dram_indep: assert property (p_dram_indep) else $error("upper range dram mode ignored");
   property p_addr_phase;
      @(posedge sys_clk) disable iff (rst)
      (state_reg == ST_T1 && !tick && addr_phase_en_reg && !hold_reg) |=> !muxed_addr_data_oe_n
         && muxed_addr_data_out == addr_reg[DATA_W-1:0];
   endproperty
   a_addr_phase: assert property (p_addr_phase) else $error("muxed address phase missing");
   property p_suppress;
      @(posedge sys_clk) disable iff (rst)
      (!addr_phase_en_reg && ale_reg) |-> muxed_addr_data_oe_n;
   endproperty
   a_suppress: assert property (p_suppress) else $error("address phase not suppressed");
   property p_hold_muxed;
      @(posedge sys_clk) disable iff (rst)
      hold_reg |-> muxed_addr_data_oe_n && !muxed_addr_data_pd_en;
   endproperty
   a_hold_muxed: assert property (p_hold_muxed) else $error("muxed lines wrong in hold");
   property p_capture;
      @(posedge sys_clk) disable iff (rst)
      $fell(rst) |-> capture_reg == $past(muxed_addr_data_in, 3);
   endproperty
   a_capture: assert property (p_capture) else $error("reset capture lost pin levels");
   property p_strobe_fall;
      @(posedge sys_clk) disable iff (rst)
      $fell(ale_reg) && addr_phase_en_reg |-> $past(muxed_addr_data_out) == addr_reg[DATA_W-1:0];
   endproperty
   a_strobe_fall: assert property (p_strobe_fall) else $error("address invalid at strobe fall");
   property p_hold_ale;
      @(posedge sys_clk) disable iff (rst)
      hold_reg |-> ale_oe_n && ale_pd_en;
   endproperty
   a_hold_ale: assert property (p_hold_ale) else $error("strobe driven in hold");
   property p_wait;
      @(posedge sys_clk) disable iff (rst)
      ((state_reg == ST_T3 || state_reg == ST_TW) && tick) |=>
         state_reg == ($past(ready_s) ? ST_T4 : ST_TW);
   endproperty
   a_wait: assert property (p_wait) else $error("wait state sequence wrong");
   property p_end;
      @(posedge sys_clk) disable iff (rst)
      (state_reg == ST_T4 && tick) |=> done_reg && state_reg == ST_IDLE;
   endproperty
   a_end: assert property (p_end) else $error("cycle did not finish after fourth state");

endmodule : ebaru_core
`default_nettype wire

// File: core/ebaru_consts.svh
// constants for the external bus address/ready unit
// assumes inclusion by bare name from the core design file
`ifndef EBARU_CONSTS_SVH
`define EBARU_CONSTS_SVH
`define EBARU_ADDR_W        20
`define EBARU_DATA_W        16
`define EBARU_DRAM_ROW_BITS 10
`define EBARU_SYS_CLK_MHZ   25
`define EBARU_BUS_CLK_DIV   2
`define EBARU_CAPTURE_RST   16'h0000
`endif

// File: core/ebaru_pkg.sv
// types for the external bus address/ready unit
// assumes nothing of its surroundings
package ebaru_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_T1   = 3'b001,
      ST_T2   = 3'b010,
      ST_T3   = 3'b011,
      ST_TW   = 3'b100,
      ST_T4   = 3'b101
   } ebaru_state_t;
endpackage : ebaru_pkg

// File: tb/ebaru_mem_model.sv
// partner memory: answers reads, captures writes, stretches cycles through ready
// assumes the core's pin triples in one sys_clk domain; the muxed wire is resolved here
`timescale 1ns/1ps
`default_nettype none
module ebaru_mem_model (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        hold_ack,
   input  wire logic [15:0] ad_out,
   input  wire logic        ad_oe_n,
   input  wire logic        ale_out,
   input  wire logic [15:0] strap_word,
   input  wire logic [15:0] rd_word,
   input  wire logic [3:0]  wait_ticks,
   input  wire logic        tie_ready,
   output logic [15:0]      ad_pin,
   output logic [15:0]      wr_word,
   output logic             async_rdy,
   output logic             sync_rdy
);
   logic [15:0] last_reg;
   logic [4:0]  wait_reg;
   logic        ale_reg;
   // wire level: core first, strap resistors in reset, drift in hold since nothing pulls it
   always_comb begin
      if (!ad_oe_n) begin
         ad_pin = ad_out;
      end else if (rst) begin
         ad_pin = strap_word;
      end else if (hold_ack) begin
         ad_pin = ~last_reg;
      end else begin
         ad_pin = rd_word;
      end
   end
   // ready drops once the address is latched and moves on clock edges so waits are exact
   always_ff @(posedge sys_clk) begin
      last_reg <= ad_pin;
      ale_reg  <= ale_out;
      if (rst) begin
         wait_reg <= 5'h00;
      end else if (ale_out && !ale_reg) begin
         wait_reg <= {wait_ticks, 1'b0};
      end else if (wait_reg != 5'h00) begin
         wait_reg <= wait_reg - 5'h01;
      end
      if (!ad_oe_n && !ale_out) begin
         wr_word <= ad_pin;
      end
   end
   // tied mode holds both readies high; otherwise sync stays low and async alone paces
   assign async_rdy = tie_ready | (wait_reg == 5'h00);
   assign sync_rdy  = tie_ready;
endmodule : ebaru_mem_model
`default_nettype wire

// File: tb/tb_top.sv
// bench for the external bus front end: reads, writes, dram split, waits, hold, straps
// assumes ebaru_core and ebaru_mem_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import ebaru_pkg::*;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic        req_valid = 1'b0;
   logic        req_write = 1'b0;
   logic [19:0] req_addr = 20'h00000;
   logic [15:0] req_wdata = 16'h0000;
   logic        req_upper_region = 1'b0;
   logic        req_lower_region = 1'b0;
   logic        dram_upper_en = 1'b0;
   logic        dram_lower_en = 1'b0;
   logic        hold_req = 1'b0;
   logic        address_phase_enable_strap = 1'b1;
   logic [15:0] strap_word = 16'h0000;
   logic [15:0] rd_word = 16'h0000;
   logic [3:0]  wait_ticks = 4'h0;
   logic        tie_ready = 1'b0;
   logic        req_ready, done, hold_ack, ale_out, ale_oe_n, ale_pd_en, address_phase_enabled, bus_clock_out;
   logic        nonmux_address_oe_n, nonmux_address_pd_en, muxed_addr_data_oe_n, muxed_addr_data_pd_en;
   logic        async_ready_in, sync_ready_in;
   logic [19:0] nonmux_address_out;
   logic [15:0] rd_data, muxed_addr_data_in, muxed_addr_data_out, reset_config_capture, wr_word;
   logic [31:0] seed = 32'h0000B25A;
   logic [16:0] exp_q[$];
   logic [16:0] note;
   int          checked = 0;
   int          mismatches = 0;

   ebaru_core ebaru_core_i (.sys_clk, .rst, .req_valid, .req_ready, .req_write, .req_addr, .req_wdata,
      .req_upper_region, .req_lower_region, .dram_upper_en, .dram_lower_en, .rd_data, .done, .hold_req,
      .hold_ack, .nonmux_address_out, .nonmux_address_oe_n, .nonmux_address_pd_en, .muxed_addr_data_in,
      .muxed_addr_data_out, .muxed_addr_data_oe_n, .muxed_addr_data_pd_en, .ale_out, .ale_oe_n, .ale_pd_en,
      .bus_clock_out, .async_ready_in, .sync_ready_in, .address_phase_enable_strap, .reset_config_capture,
      .address_phase_enabled);
   ebaru_mem_model ebaru_mem_model_i (.sys_clk, .rst, .hold_ack, .ad_out(muxed_addr_data_out),
      .ad_oe_n(muxed_addr_data_oe_n), .ale_out, .strap_word, .rd_word, .wait_ticks, .ad_pin(muxed_addr_data_in),
      .wr_word, .tie_ready, .async_rdy(async_ready_in), .sync_rdy(sync_ready_in));

   always #20 sys_clk = ~sys_clk;

   function automatic logic [19:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[19:0];
   endfunction : rnd

   task automatic print_verdict();
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : print_verdict

   task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp

   // inputs move 1 ns after the edge, clear of the core's sampling
   task automatic tick();
      @(posedge sys_clk);
      #1;
   endtask : tick

   // a wait that never ends counts as a mismatch and closes the run
   task automatic await_sig(input logic want, input logic is_hold);
      int n;
      n = 0;
      while ((is_hold ? hold_ack : done) !== want && n < 60) begin
         tick();
         n++;
      end
      if (n == 60) begin
         mismatches++;
         print_verdict();
      end
   endtask : await_sig

   task automatic do_reset(input logic strap);
      rst = 1'b1;
      address_phase_enable_strap = strap;
      strap_word = 16'(rnd());
      repeat (8) tick();
      cmp(nonmux_address_oe_n & muxed_addr_data_oe_n & ale_oe_n, 1);
      cmp(nonmux_address_pd_en & muxed_addr_data_pd_en & ale_pd_en, 1);
      rst = 1'b0;
      tick();
      cmp(reset_config_capture, strap_word);
      cmp(address_phase_enabled, strap);
   endtask : do_reset

   // one bus cycle; pins checked per cycle counted from the take edge
   task automatic bus(input logic wr, input logic up, input logic [3:0] w);
      logic [19:0] a;
      logic [15:0] d;
      logic        dr;
      int          n;
      a = rnd();
      d = 16'(rnd());
      dr = up ? dram_upper_en : dram_lower_en;
      rd_word = d;
      wait_ticks = w;
      req_write = wr;
      req_addr = a;
      req_wdata = d;
      req_upper_region = up;
      req_lower_region = !up;
      req_valid = 1'b1;
      n = 0;
      while (req_ready !== 1'b1 && n < 20) begin
         tick();
         n++;
      end
      if (n == 20) begin
         mismatches++;
         print_verdict();
      end
      tick();
      req_valid = 1'b0;
      exp_q.push_back({wr, d});
      cmp(nonmux_address_out, dr ? a >> 10 : a);
      cmp(muxed_addr_data_oe_n, 1);
      cmp(bus_clock_out, 0);
      tick();
      cmp(ale_out, 1);
      cmp(bus_clock_out, 1);
      cmp(muxed_addr_data_oe_n, !address_phase_enable_strap);
      cmp(address_phase_enable_strap ? muxed_addr_data_out : a[15:0], a[15:0]);
      tick();
      cmp(ale_out, 0);
      cmp(nonmux_address_out, dr ? a & 20'h003FF : a);
      cmp(muxed_addr_data_oe_n, !wr);
      cmp(wr ? muxed_addr_data_out : d, d);
      for (n = 0; n < 60 && done !== 1'b1; n++) begin
         tick();
      end
      cmp(n >= 6 + 2 * (tie_ready ? 4'h0 : w) && n <= 8 + 2 * (tie_ready ? 4'h0 : w), 1);
      if (n == 60) begin
         mismatches++;
         print_verdict();
      end
   endtask : bus

   // results are compared as they appear, oldest note first
   always @(posedge sys_clk) begin
      #2;
      if (done === 1'b1) begin
         note = (exp_q.size() == 0) ? 17'h1FFFF : exp_q.pop_front();
         cmp(note[16] ? wr_word : rd_data, note[15:0]);
      end
   end

   initial begin
      do_reset(1'b1);
      for (int i = 0; i < 4; i++) begin
         bus(i[0], i[1], 4'h0);
      end
      dram_upper_en = 1'b1;
      bus(1'b0, 1'b1, 4'h0);
      bus(1'b1, 1'b0, 4'h0);
      dram_upper_en = 1'b0;
      dram_lower_en = 1'b1;
      bus(1'b1, 1'b0, 4'h0);
      bus(1'b0, 1'b1, 4'h0);
      dram_lower_en = 1'b0;
      bus(1'b0, 1'b0, 4'h2);
      bus(1'b1, 1'b1, 4'h1);
      tie_ready = 1'b1;
      bus(1'b1, 1'b0, 4'h3);
      tie_ready = 1'b0;
      hold_req = 1'b1;
      await_sig(1'b1, 1'b1);
      tick();
      cmp(nonmux_address_oe_n & muxed_addr_data_oe_n & ale_oe_n, 1);
      cmp({nonmux_address_pd_en, muxed_addr_data_pd_en, ale_pd_en}, 20'h00005);
      hold_req = 1'b0;
      await_sig(1'b0, 1'b1);
      do_reset(1'b0);
      bus(1'b0, 1'b0, 4'h0);
      repeat (4) tick();
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
